// [rtl/gpioc_map.svh]
`ifndef GPIOC_MAP_SVH
`define GPIOC_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define GPIOC_IDX_P5_LATCH   14'h0005
`define GPIOC_IDX_P7_LATCH   14'h0007
`define GPIOC_IDX_P8_LATCH   14'h0008
`define GPIOC_IDX_P5_READ    14'h0012
`define GPIOC_IDX_P7_READ    14'h0014
`define GPIOC_IDX_P8_READ    14'h0015
`define GPIOC_IDX_P5_DIR     14'h0F1F
`define GPIOC_IDX_P7_DIR     14'h0F21
`define GPIOC_IDX_P8_DIR     14'h0F22
`define GPIOC_IDX_P5_FSEL    14'h0F39
`define GPIOC_IDX_P7_FSEL    14'h0F3B
`define GPIOC_IDX_P8_FSEL    14'h0F3C

// ----------------------------------------------------------------
// Port widths, reset values, field masks
// ----------------------------------------------------------------
`define GPIOC_P5_W           8
`define GPIOC_P7_W           8
`define GPIOC_P8_W           5
`define GPIOC_RST_P5         8'h00
`define GPIOC_RST_P7         8'h00
`define GPIOC_RST_P8         5'h00
`define GPIOC_P5_ALT_MASK    8'h00
`define GPIOC_P7_ALT_MASK    8'h1F
`define GPIOC_P8_ALT_MASK    5'h03
`define GPIOC_P7_IRQ_LSB     5
`define GPIOC_P7_TMRA_LSB    2
`define GPIOC_P7_TMR_LSB     0
`define GPIOC_P7_DIV_BIT     4

`endif

// [rtl/gpioc_pkg.sv]
package gpioc_pkg;

	// ------------------------------------------------------------
	// Register selector
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		GPIOC_REG_NONE    = 4'h0,
		GPIOC_REG_P5_LAT  = 4'h1,
		GPIOC_REG_P7_LAT  = 4'h2,
		GPIOC_REG_P8_LAT  = 4'h3,
		GPIOC_REG_P5_RD   = 4'h4,
		GPIOC_REG_P7_RD   = 4'h5,
		GPIOC_REG_P8_RD   = 4'h6,
		GPIOC_REG_P5_DIR  = 4'h7,
		GPIOC_REG_P7_DIR  = 4'h8,
		GPIOC_REG_P8_DIR  = 4'h9,
		GPIOC_REG_P5_FSEL = 4'hA,
		GPIOC_REG_P7_FSEL = 4'hB,
		GPIOC_REG_P8_FSEL = 4'hC
	} gpioc_reg_t;

	typedef logic [7:0]  gpioc_byte_t;
	typedef logic [13:0] gpioc_idx_t;

endpackage

// [rtl/gpioc_bank_if.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Control and pin bundle between register file and one port bank
// ----------------------------------------------------------------
interface gpioc_bank_if #(
	parameter int W = 8
);
	logic [W-1:0] latch;
	logic [W-1:0] dir;
	logic [W-1:0] fsel;
	logic [W-1:0] alt_out;
	logic [W-1:0] pin_in;
	logic [W-1:0] pin_out;
	logic [W-1:0] pin_oe_n;
	logic [W-1:0] read_val;
	logic [W-1:0] sec_in;

	modport ctrl (
		output latch,
		output dir,
		output fsel,
		output alt_out,
		output pin_in,
		input  pin_out,
		input  pin_oe_n,
		input  read_val,
		input  sec_in
	);

	modport bank (
		input  latch,
		input  dir,
		input  fsel,
		input  alt_out,
		input  pin_in,
		output pin_out,
		output pin_oe_n,
		output read_val,
		output sec_in
	);
endinterface

// [rtl/gpioc_bank.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// One port: pin drive, output select and input gating
// ----------------------------------------------------------------
module gpioc_bank #(
	parameter int           W          = 8,
	parameter logic [W-1:0] ALT_MASK   = '0,
	parameter bit           FSEL_GATES = 1'b0
) (
	gpioc_bank_if.bank b
);

	logic [W-1:0] use_alt;
	logic [W-1:0] rd_gate;

	// Secondary output only where the pin has one and drives
	assign use_alt    = b.fsel & ALT_MASK & b.dir;
	assign b.pin_out  = (b.latch & ~use_alt) | (b.alt_out & use_alt);

	// Driver off in input mode so the outside level wins
	assign b.pin_oe_n = ~b.dir;

	// Function select blocks the read only on the analog port
	assign rd_gate    = FSEL_GATES ? b.fsel : '0;
	assign b.read_val = b.pin_in & ~b.dir & ~rd_gate;

	// Secondary inputs see the pin only in input mode
	assign b.sec_in   = b.pin_in & ~b.dir;

endmodule

// [rtl/gpioc_top.sv]
//Contract
//- Port 5 has eight pins, direction per bit, each an analog channel.
//- Direction bit 0 is input, 1 output; all reset to input.
//- An output pin drives its latch bit level.
//- Port 5 latch is eight read/write bits, reset to zero.
//- Port 5 select bit 1 routes pin to analog channel; resets zero.
//- Port 5 read shows pin only when direction and select both zero.
//- Port 7 has eight pins, direction per bit, shared with peripherals.
//- Port 7 input bits feed interrupt and timer inputs; bit 4 none.
//- Port 7 output with select set carries divider, pulse or PWM output.
//- Port 7 select bits 4..0 read/write, bits 7..5 read zero.
//- Port 7 read shows pin when direction is zero, else zero.
//- Port 7 latch is eight read/write bits, reset to zero.
//- Port 8 has five pins, direction per bit, two shared with timers.
`timescale 1ns/1ps
`include "gpioc_map.svh"

module gpioc_top (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   ce_i,
	// Wishbone classic slave
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [15:0]            wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	// Port 5
	input  wire logic [`GPIOC_P5_W-1:0] p5_pin_i,
	output logic      [`GPIOC_P5_W-1:0] p5_pin_o,
	output logic      [`GPIOC_P5_W-1:0] p5_pin_oe_n_o,
	output logic      [`GPIOC_P5_W-1:0] analog_chan_sel_o,
	// Port 7
	input  wire logic [`GPIOC_P7_W-1:0] p7_pin_i,
	output logic      [`GPIOC_P7_W-1:0] p7_pin_o,
	output logic      [`GPIOC_P7_W-1:0] p7_pin_oe_n_o,
	output logic      [2:0]             ext_irq_in_o,
	output logic      [1:0]             timer_a_in_o,
	// Port 8
	input  wire logic [`GPIOC_P8_W-1:0] p8_pin_i,
	output logic      [`GPIOC_P8_W-1:0] p8_pin_o,
	output logic      [`GPIOC_P8_W-1:0] p8_pin_oe_n_o,
	// Timer inputs, bits 1..0 from port 7, 3..2 from port 8
	output logic      [3:0]             timer_in_o,
	// Peripheral outputs to be routed out
	input  wire logic                   divider_output_i,
	input  wire logic [1:0]             pulse_gen_a_out_i,
	input  wire logic [3:0]             pulse_gen_out_i,
	input  wire logic [3:0]             width_mod_out_i,
	input  wire logic [3:0]             width_mod_sel_i
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [`GPIOC_P5_W-1:0]  p5_latch_r;
	logic [`GPIOC_P5_W-1:0]  p5_dir_r;
	logic [`GPIOC_P5_W-1:0]  p5_fsel_r;
	logic [`GPIOC_P7_W-1:0]  p7_latch_r;
	logic [`GPIOC_P7_W-1:0]  p7_dir_r;
	logic [`GPIOC_P7_W-1:0]  p7_fsel_r;
	logic [`GPIOC_P8_W-1:0]  p8_latch_r;
	logic [`GPIOC_P8_W-1:0]  p8_dir_r;
	logic [`GPIOC_P8_W-1:0]  p8_fsel_r;
	logic                    ack_r;
	logic [31:0]             dat_r;
	logic [31:0]             dat_nxt;
	logic                    req;
	logic                    wr_en;
	logic [7:0]              wr_byte;
	gpioc_pkg::gpioc_idx_t   idx;
	gpioc_pkg::gpioc_reg_t   sel_reg;
	logic [3:0]              pwm_or_ppg;
	logic [`GPIOC_P7_W-1:0]  p7_alt;
	logic [`GPIOC_P8_W-1:0]  p8_alt;

	gpioc_bank_if #(.W(`GPIOC_P5_W)) p5_if ();
	gpioc_bank_if #(.W(`GPIOC_P7_W)) p7_if ();
	gpioc_bank_if #(.W(`GPIOC_P8_W)) p8_if ();

	// ------------------------------------------------------------
	// Bus request and address decode
	// ------------------------------------------------------------

	// Offsets are word indices, low two address bits ignored
	assign req     = wb_cyc_i & wb_stb_i;
	assign idx     = wb_adr_i[15:2];
	assign wr_byte = wb_dat_i[7:0];

	// Registers are at most eight bits wide, so only byte lane 0 reaches them;
	// a write with lane 0 off is still answered but stores nothing
	// Write lands on the edge the master sees ack; lane 0 only
	assign wr_en   = ce_i & req & wb_we_i & ack_r & wb_sel_i[0];

	// Index to register selector; anything else is unmapped
	always_comb begin
		case (idx)
			`GPIOC_IDX_P5_LATCH: sel_reg = gpioc_pkg::GPIOC_REG_P5_LAT;
			`GPIOC_IDX_P7_LATCH: sel_reg = gpioc_pkg::GPIOC_REG_P7_LAT;
			`GPIOC_IDX_P8_LATCH: sel_reg = gpioc_pkg::GPIOC_REG_P8_LAT;
			`GPIOC_IDX_P5_READ:  sel_reg = gpioc_pkg::GPIOC_REG_P5_RD;
			`GPIOC_IDX_P7_READ:  sel_reg = gpioc_pkg::GPIOC_REG_P7_RD;
			`GPIOC_IDX_P8_READ:  sel_reg = gpioc_pkg::GPIOC_REG_P8_RD;
			`GPIOC_IDX_P5_DIR:   sel_reg = gpioc_pkg::GPIOC_REG_P5_DIR;
			`GPIOC_IDX_P7_DIR:   sel_reg = gpioc_pkg::GPIOC_REG_P7_DIR;
			`GPIOC_IDX_P8_DIR:   sel_reg = gpioc_pkg::GPIOC_REG_P8_DIR;
			`GPIOC_IDX_P5_FSEL:  sel_reg = gpioc_pkg::GPIOC_REG_P5_FSEL;
			`GPIOC_IDX_P7_FSEL:  sel_reg = gpioc_pkg::GPIOC_REG_P7_FSEL;
			`GPIOC_IDX_P8_FSEL:  sel_reg = gpioc_pkg::GPIOC_REG_P8_FSEL;
			default:             sel_reg = gpioc_pkg::GPIOC_REG_NONE;
		endcase
	end

	// ------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------

	// Low ce_i stalls the answer; the request is taken once it rises
	// A strobe held through ack is taken again, so ack toggles
	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else if (ce_i) begin
			ack_r <= req & ~ack_r;
		end
	end

	assign wb_ack_o = ack_r;

	// Read mux; narrow registers zero-extend, unmapped reads zero
	always_comb begin
		dat_nxt = 32'h0000_0000;
		unique case (sel_reg)
			gpioc_pkg::GPIOC_REG_P5_LAT:  dat_nxt[7:0] = p5_latch_r;
			gpioc_pkg::GPIOC_REG_P7_LAT:  dat_nxt[7:0] = p7_latch_r;
			gpioc_pkg::GPIOC_REG_P8_LAT:  dat_nxt[4:0] = p8_latch_r;
			gpioc_pkg::GPIOC_REG_P5_RD:   dat_nxt[7:0] = p5_if.read_val;
			gpioc_pkg::GPIOC_REG_P7_RD:   dat_nxt[7:0] = p7_if.read_val;
			gpioc_pkg::GPIOC_REG_P8_RD:   dat_nxt[4:0] = p8_if.read_val;
			gpioc_pkg::GPIOC_REG_P5_DIR:  dat_nxt[7:0] = p5_dir_r;
			gpioc_pkg::GPIOC_REG_P7_DIR:  dat_nxt[7:0] = p7_dir_r;
			gpioc_pkg::GPIOC_REG_P8_DIR:  dat_nxt[4:0] = p8_dir_r;
			gpioc_pkg::GPIOC_REG_P5_FSEL: dat_nxt[7:0] = p5_fsel_r;
			gpioc_pkg::GPIOC_REG_P7_FSEL: dat_nxt[7:0] = p7_fsel_r;
			gpioc_pkg::GPIOC_REG_P8_FSEL: dat_nxt[4:0] = p8_fsel_r;
			gpioc_pkg::GPIOC_REG_NONE:    dat_nxt      = 32'h0000_0000;
		endcase
	end

	// No synchroniser: pins are taken as synchronous to clk_i
	// Pin level is sampled on the edge that raises ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= 32'h0000_0000;
		end else if (ce_i && req && !ack_r) begin
			dat_r <= dat_nxt;
		end
	end

	assign wb_dat_o = dat_r;

	// ------------------------------------------------------------
	// Port 5 registers
	// ------------------------------------------------------------

	// Output latch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p5_latch_r <= `GPIOC_RST_P5;
		end else if (wr_en && sel_reg == gpioc_pkg::GPIOC_REG_P5_LAT) begin
			p5_latch_r <= wr_byte;
		end
	end

	// Direction, one bit per pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p5_dir_r <= `GPIOC_RST_P5;
		end else if (wr_en && sel_reg == gpioc_pkg::GPIOC_REG_P5_DIR) begin
			p5_dir_r <= wr_byte;
		end
	end

	// Function select, analog routing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p5_fsel_r <= `GPIOC_RST_P5;
		end else if (wr_en && sel_reg == gpioc_pkg::GPIOC_REG_P5_FSEL) begin
			p5_fsel_r <= wr_byte;
		end
	end

	// ------------------------------------------------------------
	// Port 7 registers
	// ------------------------------------------------------------

	// Output latch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p7_latch_r <= `GPIOC_RST_P7;
		end else if (wr_en && sel_reg == gpioc_pkg::GPIOC_REG_P7_LAT) begin
			p7_latch_r <= wr_byte;
		end
	end

	// Direction, one bit per pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p7_dir_r <= `GPIOC_RST_P7;
		end else if (wr_en && sel_reg == gpioc_pkg::GPIOC_REG_P7_DIR) begin
			p7_dir_r <= wr_byte;
		end
	end

	// Function select; upper bits hold zero, writes there dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p7_fsel_r <= `GPIOC_RST_P7;
		end else if (wr_en && sel_reg == gpioc_pkg::GPIOC_REG_P7_FSEL) begin
			p7_fsel_r <= wr_byte & `GPIOC_P7_ALT_MASK;
		end
	end

	// ------------------------------------------------------------
	// Port 8 registers
	// ------------------------------------------------------------

	// Output latch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p8_latch_r <= `GPIOC_RST_P8;
		end else if (wr_en && sel_reg == gpioc_pkg::GPIOC_REG_P8_LAT) begin
			p8_latch_r <= wr_byte[`GPIOC_P8_W-1:0];
		end
	end

	// Direction, one bit per pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p8_dir_r <= `GPIOC_RST_P8;
		end else if (wr_en && sel_reg == gpioc_pkg::GPIOC_REG_P8_DIR) begin
			p8_dir_r <= wr_byte[`GPIOC_P8_W-1:0];
		end
	end

	// Function select, only the two timer pins implemented
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p8_fsel_r <= `GPIOC_RST_P8;
		end else if (wr_en && sel_reg == gpioc_pkg::GPIOC_REG_P8_FSEL) begin
			p8_fsel_r <= wr_byte[`GPIOC_P8_W-1:0] & `GPIOC_P8_ALT_MASK;
		end
	end

	// ------------------------------------------------------------
	// Secondary output routing
	// ------------------------------------------------------------

	// Timer chooses pulse or width mode; width_mod_sel_i picks the output here per channel
	assign pwm_or_ppg = (width_mod_out_i & width_mod_sel_i)
	                  | (pulse_gen_out_i & ~width_mod_sel_i);

	// Port 7: bit 4 divider, bits 3..2 pulse A, bits 1..0 timer
	assign p7_alt = {3'h0, divider_output_i, pulse_gen_a_out_i, pwm_or_ppg[1:0]};

	// Port 8: bits 1..0 carry timer channels 2 and 3
	assign p8_alt = {3'h0, pwm_or_ppg[3:2]};

	// ------------------------------------------------------------
	// Bank connections
	// ------------------------------------------------------------
	// Port 5 has no secondary output; its alternate lane stays low
	assign p5_if.latch   = p5_latch_r;
	assign p5_if.dir     = p5_dir_r;
	assign p5_if.fsel    = p5_fsel_r;
	assign p5_if.alt_out = '0;
	assign p5_if.pin_in  = p5_pin_i;

	// Port 7 lower five pins can carry divider and timer outputs
	assign p7_if.latch   = p7_latch_r;
	assign p7_if.dir     = p7_dir_r;
	assign p7_if.fsel    = p7_fsel_r;
	assign p7_if.alt_out = p7_alt;
	assign p7_if.pin_in  = p7_pin_i;

	// Port 8 timer pins carry channels 2 and 3
	assign p8_if.latch   = p8_latch_r;
	assign p8_if.dir     = p8_dir_r;
	assign p8_if.fsel    = p8_fsel_r;
	assign p8_if.alt_out = p8_alt;
	assign p8_if.pin_in  = p8_pin_i;

	// Analog port: select bit also blocks the digital read
	gpioc_bank #(
		.W          (`GPIOC_P5_W),
		.ALT_MASK   (`GPIOC_P5_ALT_MASK),
		.FSEL_GATES (1'b1)
	) u_p5 (
		.b (p5_if.bank)
	);

	// Port 7 reads the pin in input mode whatever the select
	gpioc_bank #(
		.W          (`GPIOC_P7_W),
		.ALT_MASK   (`GPIOC_P7_ALT_MASK),
		.FSEL_GATES (1'b0)
	) u_p7 (
		.b (p7_if.bank)
	);

	// Port 8 read follows direction only, as on port 7
	gpioc_bank #(
		.W          (`GPIOC_P8_W),
		.ALT_MASK   (`GPIOC_P8_ALT_MASK),
		.FSEL_GATES (1'b0)
	) u_p8 (
		.b (p8_if.bank)
	);

	// ------------------------------------------------------------
	// Pins and secondary inputs
	// ------------------------------------------------------------
	// Enables are active low: a set direction bit pulls its enable down
	assign p5_pin_o      = p5_if.pin_out;
	assign p5_pin_oe_n_o = p5_if.pin_oe_n;
	assign p7_pin_o      = p7_if.pin_out;
	assign p7_pin_oe_n_o = p7_if.pin_oe_n;
	assign p8_pin_o      = p8_if.pin_out;
	assign p8_pin_oe_n_o = p8_if.pin_oe_n;

	// Pin n feeds analog channel n plus 8 when selected
	assign analog_chan_sel_o = p5_fsel_r;

	// Interrupt inputs 2..4 from bits 5..7; bit 4 feeds nothing
	assign ext_irq_in_o = p7_if.sec_in[`GPIOC_P7_IRQ_LSB +: 3];
	assign timer_a_in_o = p7_if.sec_in[`GPIOC_P7_TMRA_LSB +: 2];
	assign timer_in_o   = {p8_if.sec_in[1:0], p7_if.sec_in[`GPIOC_P7_TMR_LSB +: 2]};

endmodule

// [bench/gpioc_pins_model.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Board side of one port: resolves each pad from both drivers
// ----------------------------------------------------------------
module gpioc_pins_model #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] pin_o_i,
	input  wire logic [W-1:0] oe_n_i,
	input  wire logic [W-1:0] ext_i,
	output logic      [W-1:0] pin_i_o
);
	// External source backs off where the device drives, no contention
	always_comb pin_i_o = (pin_o_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule

// [bench/gpioc_top_props.sv]
`timescale 1ns/1ps

module gpioc_top_props (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [7:0]  p5_pin_i,
	input wire logic [7:0]  p5_pin_o,
	input wire logic [7:0]  p5_pin_oe_n_o,
	input wire logic [7:0]  analog_chan_sel_o,
	input wire logic [7:0]  p7_pin_i,
	input wire logic [7:0]  p7_pin_oe_n_o,
	input wire logic [2:0]  ext_irq_in_o,
	input wire logic [1:0]  timer_a_in_o,
	input wire logic [3:0]  timer_in_o
);
	// Request taken, write committed, and the gated pin views
	logic       req;
	logic       wr;
	logic [7:0] wd;
	logic [7:0] g5;
	logic [7:0] g7;
	assign req = wb_cyc_i & wb_stb_i & ce_i & ~wb_ack_o;
	assign wr  = wb_cyc_i & wb_stb_i & ce_i & wb_ack_o & wb_we_i & wb_sel_i[0];
	assign wd  = wb_dat_i[7:0];
	assign g5  = p5_pin_i & p5_pin_oe_n_o & ~analog_chan_sel_o;
	assign g7  = p7_pin_i & p7_pin_oe_n_o;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_next: assert property (req |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_single: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_dat_hold: assert property (!req |=> $stable(wb_dat_o))
		else $error("read data moved without request");
	a_dir_reset: assert property ($past(rst_i) |-> p5_pin_oe_n_o == 8'hFF
		&& p7_pin_oe_n_o == 8'hFF && analog_chan_sel_o == 8'h00 && p5_pin_o == 8'h00)
		else $error("pins not released after reset");
	a_dir_write: assert property (wr && wb_adr_i == 16'h3C7C |=>
		(p5_pin_oe_n_o ^ $past(wd)) == 8'hFF) else $error("enable not inverse of dir");
	a_latch_drive: assert property (wr && wb_adr_i == 16'h0014 |=>
		p5_pin_o == $past(wd)) else $error("pin level not latch");
	a_analog_sel: assert property (wr && wb_adr_i == 16'h3CE4 |=>
		analog_chan_sel_o == $past(wd)) else $error("analog select wrong");
	a_p5_read: assert property (req && !wb_we_i && wb_adr_i == 16'h0048 |=>
		wb_dat_o == {24'h000000, $past(g5)}) else $error("port5 read gating");
	a_p7_read: assert property (req && !wb_we_i && wb_adr_i == 16'h0050 |=>
		wb_dat_o == {24'h000000, $past(g7)}) else $error("port7 read gating");
	a_fsel_upper: assert property (req && !wb_we_i && wb_adr_i == 16'h3CEC |=>
		wb_dat_o[31:5] == 27'h0000000) else $error("fsel upper bits set");
	a_irq_gate: assert property (ext_irq_in_o == g7[7:5])
		else $error("irq input gating");
	a_timer_gate: assert property ({timer_a_in_o, timer_in_o[1:0]} == g7[3:0])
		else $error("timer input gating");

	a_ce_freeze: assert property (!ce_i |=> $stable(wb_ack_o) && $stable(wb_dat_o)
		&& $stable(p5_pin_o) && $stable(p5_pin_oe_n_o)) else $error("state moved while disabled");

	c_fsel_write: cover property (wr && wb_adr_i == 16'h3CEC);
	c_irq_seen: cover property (ext_irq_in_o == 3'h7);
	c_p5_read: cover property (req && !wb_we_i && wb_adr_i == 16'h0048 ##1 wb_dat_o != 32'h0);
endmodule

bind gpioc_top gpioc_top_props u_gpioc_top_props (
	.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_dat_o, .wb_ack_o, .p5_pin_i, .p5_pin_o, .p5_pin_oe_n_o,
	.analog_chan_sel_o, .p7_pin_i, .p7_pin_oe_n_o, .ext_irq_in_o, .timer_a_in_o,
	.timer_in_o
);

// [bench/gpioc_top_tb.sv]
`timescale 1ns/1ps

module gpioc_top_tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc   = 1'b0;
	logic        stb   = 1'b0;
	logic        we    = 1'b0;
	logic [15:0] adr   = 16'h0000;
	logic [31:0] dat   = 32'h00000000;
	logic [31:0] q;
	logic [31:0] dat_o;
	logic        ack;
	logic        ce    = 1'b1;
	logic [3:0]  sel   = 4'h1;
	logic [3:0]  lane  = 4'h1;
	logic [7:0]  e5 = 8'h00, e7 = 8'h00, p5o, p5e, p5i, an, p7o, p7e, p7i;
	logic [4:0]  e8 = 5'h00, p8o, p8e, p8i;
	logic        div = 1'b0;
	logic [1:0]  pga = 2'h0, ta;
	logic [3:0]  pg = 4'h0, pw = 4'h0, ps = 4'h0, tin;
	logic [2:0]  irq;
	int          fail_count = 0;
	int          num_checks = 0;

	always #25 clk_i = ~clk_i;

	gpioc_top u_gpioc_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .p5_pin_i(p5i), .p5_pin_o(p5o),
		.p5_pin_oe_n_o(p5e), .analog_chan_sel_o(an), .p7_pin_i(p7i), .p7_pin_o(p7o),
		.p7_pin_oe_n_o(p7e), .ext_irq_in_o(irq), .timer_a_in_o(ta), .p8_pin_i(p8i),
		.p8_pin_o(p8o), .p8_pin_oe_n_o(p8e), .timer_in_o(tin), .divider_output_i(div),
		.pulse_gen_a_out_i(pga), .pulse_gen_out_i(pg), .width_mod_out_i(pw),
		.width_mod_sel_i(ps));
	gpioc_pins_model #(.W(8)) u_gpioc_pins_model_p5 (.pin_o_i(p5o), .oe_n_i(p5e),
		.ext_i(e5), .pin_i_o(p5i));
	gpioc_pins_model #(.W(8)) u_gpioc_pins_model_p7 (.pin_o_i(p7o), .oe_n_i(p7e),
		.ext_i(e7), .pin_i_o(p7i));
	gpioc_pins_model #(.W(5)) u_gpioc_pins_model_p8 (.pin_o_i(p8o), .oe_n_i(p8e),
		.ext_i(e8), .pin_i_o(p8i));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("Error %0t: %s seen %h expected %h", $time, m, s, e);
		end
	endtask

	// Classic cycle; waits for ack under a bound, never assumes latency
	task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		sel <= lane;
		adr <= a;
		dat <= {24'h000000, d};
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk_i);
		end
		chk(32'(n < 20), 32'h1, "bus answer");
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic rc(input logic [15:0] a, input logic [31:0] e, input string m);
		wb(1'b0, a, 8'h00);
		chk(q, e, m);
	endtask

	task automatic results();
		$display("Checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [15:0] ra [6] = '{16'h0014, 16'h001C, 16'h3C7C, 16'h3C84, 16'h3CE4, 16'h3CEC};
		#1;
		chk({p5e, p7e}, 16'hFFFF, "pins released");
		chk(p8e, 5'h1F, "port8 released");
		chk(an, 8'h00, "analog select");
		foreach (ra[i]) rc(ra[i], 32'h0, "reset value");
		wb(1'b1, 16'h0100, 8'hFF);
		rc(16'h0100, 32'h0, "unmapped");
	endtask

	task automatic t_p5();
		@(posedge clk_i);
		e5 <= 8'hFF;
		wb(1'b1, 16'h0014, 8'hA5);
		wb(1'b1, 16'h3C7C, 8'h0F);
		wb(1'b1, 16'h3CE4, 8'h3C);
		#1;
		chk(p5e, 8'hF0, "port5 enables");
		chk(p5o, 8'hA5, "port5 drive");
		chk(an, 8'h3C, "analog routing");
		rc(16'h0048, 32'hC0, "port5 pin read");
		rc(16'h0014, 32'hA5, "port5 latch");
		rc(16'h3CE4, 32'h3C, "port5 fsel");
	endtask

	// Secondary outputs replace the latch only on fsel bits in output mode
	task automatic t_p7();
		@(posedge clk_i);
		e7  <= 8'hFF;
		div <= 1'b1;
		pga <= 2'h3;
		pw  <= 4'h1;
		pg  <= 4'h2;
		ps  <= 4'h1;
		wb(1'b1, 16'h3CEC, 8'hFF);
		rc(16'h3CEC, 32'h1F, "port7 fsel");
		wb(1'b1, 16'h3C84, 8'h1F);
		#1;
		chk(p7o, 8'h1F, "secondary drive");
		chk(p7e, 8'hE0, "port7 enables");
		chk(irq, 3'h7, "irq inputs");
		@(posedge clk_i);
		div <= 1'b0;
		pga <= 2'h0;
		pw  <= 4'h0;
		pg  <= 4'h1;
		#1;
		chk(p7o, 8'h00, "secondary low");
		wb(1'b1, 16'h001C, 8'hA6);
		#1;
		chk(p7o, 8'hA0, "latch on plain bits");
		rc(16'h001C, 32'hA6, "port7 latch");
		wb(1'b1, 16'h3C84, 8'hE0);
		#1;
		chk({irq, ta, tin[1:0]}, 7'h0F, "timer inputs");
		rc(16'h0050, 32'h1F, "port7 pin read");
	endtask

	task automatic t_p8();
		@(posedge clk_i);
		e8 <= 5'h1F;
		wb(1'b1, 16'h3C88, 8'h15);
		wb(1'b1, 16'h0020, 8'h1F);
		#1;
		chk({p8e, p8o}, 10'h15F, "port8 drive");
		chk(tin[3:2], 2'h2, "port8 timer");
		rc(16'h0054, 32'h0A, "port8 pin read");
		wb(1'b1, 16'h3CF0, 8'hFF);
		rc(16'h3CF0, 32'h03, "port8 fsel");
		@(posedge clk_i);
		pw <= 4'h4;
		ps <= 4'h5;
		#1;
		chk(p8o, 5'h1F, "port8 width mode");
		@(posedge clk_i);
		pw <= 4'h0;
		#1;
		chk(p8o, 5'h1E, "port8 secondary low");
	endtask

	// Low enable stalls a write; a write without lane 0 stores nothing
	task automatic t_ce();
		@(posedge clk_i);
		ce <= 1'b0;
		fork
			wb(1'b1, 16'h0014, 8'h5A);
			begin
				repeat (3) @(posedge clk_i);
				chk(ack, 1'b0, "ack while disabled");
				ce <= 1'b1;
			end
		join
		#1;
		chk(p5o, 8'h5A, "latch after enable");
		lane = 4'h2;
		wb(1'b1, 16'h0014, 8'hFF);
		lane = 4'h1;
		rc(16'h0014, 32'h5A, "lane 0 only");
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_p5();
		t_p7();
		t_p8();
		t_ce();
		@(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		results();
	end

	// Whole run is some 130 cycles of 50 ns; the 4000-cycle limit allows ample margin
	initial begin
		#200000;
		fail_count++;
		results();
	end
endmodule
